// ---- bench/rspr_checker.sv ----
// Port-level assertions for the speed and power readout
`timescale 1ns/1ps
module rspr_checker (
    input wire logic                    clk,
    input wire logic                    arst_n,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire rspr_pkg::rspr_filt_type filter_sel,
    input wire logic [31:0]             speed_rpm,
    input wire logic [31:0]             power_value,
    input wire logic                    stopped
);
    import rspr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_filt;
        $changed(filter_sel) |-> s_axi_bvalid;
    endproperty
    a_filt: assert property (p_filt) else $error("filter moved");
    property p_stop;
        stopped |-> speed_rpm == 32'h0;
    endproperty
    a_stop: assert property (p_stop) else $error("speed not zero");
    property p_pwr;
        $rose(stopped) |-> ##[1:300] power_value == 32'h0;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power not zero");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_bans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> ##1 s_axi_bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_rans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
    property p_rdone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdone: assert property (p_rdone) else $error("rvalid stuck");
endmodule : rspr_checker
bind rspr_top rspr_checker chk_i (.*);

// ---- bench/rspr_sensor.sv ----
// Behavioural rotation sensor driving the speed pulse line
`timescale 1ns/1ps
module rspr_sensor (
    input  wire logic        clk,
    input  wire logic [31:0] period,
    output logic             pulse
);
    logic [31:0] cnt = 32'h0;
    initial pulse = 1'b0;
    // Period 0 parks the line low, as a shaft at rest would
    always @(posedge clk) begin
        if (period == 32'h0) begin
            cnt <= 32'h0;
            pulse <= 1'b0;
        end else begin
            cnt <= (cnt >= period - 32'h1) ? 32'h0 : cnt + 32'h1;
            pulse <= (cnt < (period >> 1));
        end
    end
endmodule : rspr_sensor

// ---- bench/tb.sv ----
// Register-level bench for the speed and power readout
`timescale 1ns/1ps
module tb;
    import rspr_pkg::*;
    logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, speed_pulse, stopped;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, speed_rpm, power_value, per, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [19:0] torque_mnm;
    rspr_filt_type filter_sel;
    int failures = 0;
    int checks_done = 0;
    // Short millisecond keeps the detection times between 4000 and 30000 cycles
    rspr_top #(.CYC_PER_MS(4)) dut (.*);
    rspr_sensor sen (.clk(clk), .period(per), .pulse(speed_pulse));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic pulses(input int n);
        repeat (n) @(posedge speed_pulse);
        @(posedge clk);
    endtask : pulses
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge clk);
        while (!s_axi_bvalid) begin
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            @(posedge clk);
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd32(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clk);
        while (!s_axi_rvalid) begin
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            @(posedge clk);
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd32
    function automatic logic [31:0] cfg(int pr, sd, pu, pd, pv, ms, st, fl);
        return 32'(pr | sd << 1 | pu << 3 | pd << 6 | pv << 8 | ms << 10
                   | st << 13 | fl << 15);
    endfunction : cfg
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        idle(100000);
        failures++;
        give_verdict;
    end
    initial begin
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        torque_mnm = 20'h0;
        per = 32'h0;
        idle(20);
        arst_n <= 1'b1;
        idle(2);
        chk(32'(filter_sel), 32'h2);
        rd32(8'h00);
        chk(rd, 32'h10009);
        wr(8'h20, 32'h0);
        chk(32'(rs), 32'h2);
        rd32(8'h20);
        chk({rd[31:2], rs}, 32'h2);
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, cfg(0, 2, 1, 1, 3, 0, 1, k));
            idle(2);
            chk(32'(filter_sel), 32'(k));
        end
        torque_mnm <= 20'd10000;
        per <= 32'd1030;
        pulses(4);
        idle(300);
        chk(speed_rpm, 32'd230);
        chk(power_value, 32'd2440);
        rd32(8'h04);
        chk(rd, 32'd230);
        wr(8'h00, cfg(0, 2, 2, 3, 3, 0, 1, 3));
        idle(300);
        chk(power_value, 32'd240);
        wr(8'h00, cfg(1, 2, 2, 3, 3, 0, 1, 3));
        rd32(8'h00);
        chk(rd, cfg(1, 2, 2, 3, 3, 0, 1, 3));
        pulses(3);
        idle(300);
        chk(speed_rpm, 32'd55);
        chk(power_value, 32'd60);
        pulses(1);
        per <= 32'h0;
        idle(1500);
        chk(speed_rpm, 32'd55);
        idle(700);
        chk(32'(stopped), 32'h1);
        wr(8'h00, cfg(1, 2, 2, 3, 3, 2, 0, 3));
        per <= 32'd1030;
        pulses(4);
        idle(300);
        pulses(1);
        per <= 32'h0;
        idle(11500);
        chk(32'(stopped), 32'h0);
        idle(1000);
        chk(speed_rpm, 32'h0);
        give_verdict;
    end
endmodule : tb

// ---- hdl/rspr_consts.svh ----
// Constants for the rotation speed and power readout block
`ifndef RSPR_CONSTS_SVH
`define RSPR_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define RSPR_CLK_HZ          40000000
`define RSPR_CLK_PERIOD_NS   25
`define RSPR_MS_PER_SEC      1000
`define RSPR_SEC_PER_MIN     60

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RSPR_OFS_CFG         8'h00
`define RSPR_OFS_SPEED       8'h04
`define RSPR_OFS_POWER       8'h08
`define RSPR_OFS_STATUS      8'h0c
`define RSPR_OFS_PERIOD      8'h10

// ----------------------------------------------------------------------
// Configuration field positions and reset value
// ----------------------------------------------------------------------
`define RSPR_F_PRATE         0
`define RSPR_F_SDIV          1
`define RSPR_F_PUNIT         3
`define RSPR_F_PDEC          6
`define RSPR_F_PDIV          8
`define RSPR_F_MINSPD        10
`define RSPR_F_STOP          13
`define RSPR_F_FILT          15
`define RSPR_CFG_BITS        17
`define RSPR_CFG_RST         17'h10009

// ----------------------------------------------------------------------
// Pulses per rotation, maximum detection times in ms
// ----------------------------------------------------------------------
`define RSPR_PPR_ONE         1
`define RSPR_PPR_FOUR        4
`define RSPR_MAXDET0_MS      32'd1000
`define RSPR_MAXDET1_MS      32'd1500
`define RSPR_MAXDET2_MS      32'd3000
`define RSPR_MAXDET3_MS      32'd5000
`define RSPR_MAXDET4_MS      32'd7500

// ----------------------------------------------------------------------
// Power arithmetic: omega = 0.1047198 in Q16, unit sizes in mW
// ----------------------------------------------------------------------
`define RSPR_OMEGA_Q16       64'd6863
`define RSPR_OMEGA_FRAC      16
`define RSPR_MW_PER_MW       64'd1
`define RSPR_MW_PER_W        64'd1000
`define RSPR_MW_PER_KW       64'd1000000
`define RSPR_MW_PER_PS       64'd735500
`define RSPR_MW_PER_HP       64'd745700
`define RSPR_STEP_5          32'd5
`define RSPR_STEP_10         32'd10

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define RSPR_RESP_OKAY       2'b00
`define RSPR_RESP_SLVERR     2'b10

`endif

// ---- hdl/rspr_div.sv ----
// Iterative restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps

module rspr_div #(
    parameter int W = 64
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quotient
);

    localparam int CW = $clog2(W);

    logic [W:0]    rem_reg;
    logic [W-1:0]  den_reg;
    logic [CW-1:0] cnt_reg;
    logic [W:0]    rem_sh;
    logic [W:0]    trial;

    assign rem_sh = {rem_reg[W-1:0], quotient[W-1]};
    assign trial  = rem_sh - {1'b0, den_reg};

    // Divisor zero gives all ones; callers never pass zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_reg  <= '0;
            den_reg  <= '0;
            cnt_reg  <= '0;
            quotient <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_reg  <= '0;
                den_reg  <= divisor;
                quotient <= dividend;
                cnt_reg  <= '0;
                busy     <= 1'b1;
            end else if (busy) begin
                if (!trial[W]) begin
                    rem_reg  <= trial;
                    quotient <= {quotient[W-2:0], 1'b1};
                end else begin
                    rem_reg  <= rem_sh;
                    quotient <= {quotient[W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg == CW'(W - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule : rspr_div

// ---- hdl/rspr_pkg.sv ----
// Types shared by the rotation speed and power readout block
package rspr_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_rpm,
        st_pwr
    } rspr_state_type;

    typedef logic [1:0] rspr_filt_type;

endpackage : rspr_pkg

// ---- hdl/rspr_top.sv ----
// Rotation speed and power readout with AXI4-Lite register access
//
// How it works
// - Pulse-rate code 0 reads one pulse per rotation and code 1 four.
// - Speed is rounded down to a step of 1, 2, 5 or 10 for codes 0 to 3.
// - Power unit codes 0 to 4 are mW, W, kW, PS and HP, decimals kept.
// - Decimal codes 0 to 3 give 0 to 3 fractional digits, unit kept.
// - Power is rounded toward zero to a step of 1, 2, 5 or 10 counts.
// - Minimum-speed codes 0 to 4 give 1, 1.5, 3, 5 and 7.5 s waits.
// - Those waits floor speed at 15/10/5/3/2 rpm (x4) or 60/40/20/12/8.
// - Without a new pulse the last measured speed is held.
// - Stop code 0 zeroes speed only after the full detection time.
// - Stop codes 1 to 3 zero speed after 2, 4 or 8 last periods.
// - Power in W is torque in Nm times rpm times 0.1047198.
// - Power is scaled to the unit, with PS 0.7355 kW and HP 0.7457 kW.
// - The filter output selects 3 Hz, 30 Hz, 300 Hz or 1 kHz by 0 to 3.
// - Reset loads pulse rate 1, scale divisions 0 and power unit 1.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "rspr_consts.svh"

module rspr_top #(
    parameter int ADDR_W     = 8,
    parameter int TQ_W       = 20,
    parameter int RPM_W      = 20,
    parameter int CYC_PER_MS = `RSPR_CLK_HZ / `RSPR_MS_PER_SEC
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  speed_pulse,
    input  wire logic [TQ_W-1:0]       torque_mnm,
    output rspr_pkg::rspr_filt_type    filter_sel,
    output logic [31:0]                speed_rpm,
    output logic [31:0]                power_value,
    output logic                       stopped
);
    import rspr_pkg::*;

    localparam int DW = 64;
    localparam logic [DW-1:0] RPM_NUM_ONE = 64'(`RSPR_SEC_PER_MIN)
        * 64'(`RSPR_MS_PER_SEC) * 64'(CYC_PER_MS) / 64'(`RSPR_PPR_ONE);
    localparam logic [DW-1:0] RPM_NUM_FOUR = 64'(`RSPR_SEC_PER_MIN)
        * 64'(`RSPR_MS_PER_SEC) * 64'(CYC_PER_MS) / 64'(`RSPR_PPR_FOUR);
    localparam logic [31:0] MAX_POS = 32'h7fffffff;

    // ------------------------------------------------------------------
    // Configuration register and its fields
    // ------------------------------------------------------------------
    logic [`RSPR_CFG_BITS-1:0] cfg_reg;
    logic                      prate;
    logic [1:0]                sdiv;
    logic [2:0]                punit;
    logic [1:0]                pdec;
    logic [1:0]                pdiv;
    logic [2:0]                minspd;
    logic [1:0]                stop_code;

    assign prate     = cfg_reg[`RSPR_F_PRATE];
    assign sdiv      = cfg_reg[`RSPR_F_SDIV +: 2];
    assign punit     = cfg_reg[`RSPR_F_PUNIT +: 3];
    assign pdec      = cfg_reg[`RSPR_F_PDEC +: 2];
    assign pdiv      = cfg_reg[`RSPR_F_PDIV +: 2];
    assign minspd    = cfg_reg[`RSPR_F_MINSPD +: 3];
    assign stop_code = cfg_reg[`RSPR_F_STOP +: 2];

    function automatic logic [31:0] rspr_quant(input logic [31:0] v,
                                               input logic [1:0]  code);
        case (code)
            2'd0:    rspr_quant = v;
            2'd1:    rspr_quant = {v[31:1], 1'b0};
            2'd2:    rspr_quant = v - (v % `RSPR_STEP_5);
            default: rspr_quant = v - (v % `RSPR_STEP_10);
        endcase
    endfunction : rspr_quant

    // ------------------------------------------------------------------
    // Pulse input synchroniser and edge
    // ------------------------------------------------------------------
    logic pulse_s1_reg;
    logic pulse_s2_reg;
    logic pulse_d_reg;
    logic pulse_edge;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_s1_reg <= 1'b0;
            pulse_s2_reg <= 1'b0;
            pulse_d_reg  <= 1'b0;
        end else begin
            pulse_s1_reg <= speed_pulse;
            pulse_s2_reg <= pulse_s1_reg;
            pulse_d_reg  <= pulse_s2_reg;
        end
    end

    assign pulse_edge = pulse_s2_reg & ~pulse_d_reg;

    // ------------------------------------------------------------------
    // Detection time and stop limit
    // ------------------------------------------------------------------
    logic [31:0] maxdet_ms;
    logic [31:0] maxdet_cyc;
    logic [34:0] stop_lim;
    logic [34:0] limit;
    logic [31:0] cnt_reg;
    logic [31:0] period_reg;
    logic        armed_reg;
    logic        have_reg;
    logic        pend_reg;
    logic        take;
    logic        timeout;
    logic        zero_evt;

    always_comb begin
        case (minspd)
            3'd0:    maxdet_ms = `RSPR_MAXDET0_MS;
            3'd1:    maxdet_ms = `RSPR_MAXDET1_MS;
            3'd2:    maxdet_ms = `RSPR_MAXDET2_MS;
            3'd3:    maxdet_ms = `RSPR_MAXDET3_MS;
            default: maxdet_ms = `RSPR_MAXDET4_MS;
        endcase
    end

    assign maxdet_cyc = maxdet_ms * 32'(CYC_PER_MS);
    assign stop_lim   = {3'b000, period_reg} << stop_code;
    // The multiple never stretches past the detection time
    assign limit = (stop_code != 2'd0 && have_reg
                    && stop_lim < {3'b000, maxdet_cyc})
                   ? stop_lim : {3'b000, maxdet_cyc};
    assign timeout  = armed_reg && ({3'b000, cnt_reg} >= limit);
    assign zero_evt = timeout && !pulse_edge;

    // ------------------------------------------------------------------
    // Period measurement
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg    <= '0;
            period_reg <= '0;
            armed_reg  <= 1'b0;
            have_reg   <= 1'b0;
            pend_reg   <= 1'b0;
        end else begin
            if (take) begin
                pend_reg <= 1'b0;
            end
            if (pulse_edge) begin
                cnt_reg   <= '0;
                armed_reg <= 1'b1;
                // First edge after a stop only starts the interval
                if (armed_reg) begin
                    period_reg <= cnt_reg + 32'd1;
                    pend_reg   <= 1'b1;
                    have_reg   <= 1'b1;
                end
            end else if (timeout) begin
                armed_reg <= 1'b0;
                have_reg  <= 1'b0;
            end else if (armed_reg) begin
                cnt_reg <= cnt_reg + 32'd1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Arithmetic sequencer around one shared divider
    // ------------------------------------------------------------------
    rspr_state_type  state_reg;
    rspr_state_type  state_next;
    logic            dv_start;
    logic [DW-1:0]   dv_num;
    logic [DW-1:0]   dv_den;
    logic            dv_busy;
    logic            dv_done;
    logic [DW-1:0]   dv_quo;
    logic [RPM_W-1:0] rpm_raw_reg;
    logic [TQ_W-1:0] tq_abs;
    logic [DW-1:0]   dec_pow;
    logic [DW-1:0]   unit_mw;
    logic [DW-1:0]   pwr_num;
    logic [DW-1:0]   pwr_den;
    logic [31:0]     quo_sat;
    logic [31:0]     pwr_mag;
    logic            pwr_neg_reg;

    assign tq_abs = torque_mnm[TQ_W-1] ? TQ_W'(-torque_mnm) : torque_mnm;

    always_comb begin
        case (pdec)
            2'd0:    dec_pow = 64'd1;
            2'd1:    dec_pow = 64'd10;
            2'd2:    dec_pow = 64'd100;
            default: dec_pow = 64'd1000;
        endcase
        case (punit)
            3'd0:    unit_mw = `RSPR_MW_PER_MW;
            3'd2:    unit_mw = `RSPR_MW_PER_KW;
            3'd3:    unit_mw = `RSPR_MW_PER_PS;
            3'd4:    unit_mw = `RSPR_MW_PER_HP;
            default: unit_mw = `RSPR_MW_PER_W;
        endcase
    end

    // Torque in mNm times rpm times omega gives mW in Q16
    assign pwr_num = 64'(tq_abs) * 64'(rpm_raw_reg) * `RSPR_OMEGA_Q16
                     * dec_pow;
    assign pwr_den = unit_mw << `RSPR_OMEGA_FRAC;
    assign quo_sat = (dv_quo > 64'(MAX_POS)) ? MAX_POS : dv_quo[31:0];
    assign pwr_mag = rspr_quant(quo_sat, pdiv);

    always_comb begin
        take       = 1'b0;
        dv_start   = 1'b0;
        dv_num     = pwr_num;
        dv_den     = pwr_den;
        state_next = state_reg;
        case (state_reg)
            st_idle: begin
                dv_start = 1'b1;
                if (pend_reg) begin
                    take       = 1'b1;
                    dv_num     = prate ? RPM_NUM_FOUR : RPM_NUM_ONE;
                    dv_den     = 64'(period_reg);
                    state_next = st_rpm;
                end else begin
                    state_next = st_pwr;
                end
            end
            st_rpm: begin
                if (dv_done) begin
                    state_next = st_idle;
                end
            end
            default: begin
                if (dv_done) begin
                    state_next = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= st_idle;
            pwr_neg_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == st_idle && !pend_reg) begin
                pwr_neg_reg <= torque_mnm[TQ_W-1];
            end
        end
    end

    rspr_div #(
        .W        (DW)
    ) u_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (dv_start),
        .dividend (dv_num),
        .divisor  (dv_den),
        .busy     (dv_busy),
        .done     (dv_done),
        .quotient (dv_quo)
    );

    // ------------------------------------------------------------------
    // Speed and power results
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rpm_raw_reg <= '0;
            speed_rpm   <= '0;
            stopped     <= 1'b1;
        end else if (zero_evt) begin
            rpm_raw_reg <= '0;
            speed_rpm   <= '0;
            stopped     <= 1'b1;
        end else if (state_reg == st_rpm && dv_done && have_reg) begin
            // Held until the next result or a stop
            rpm_raw_reg <= (dv_quo > 64'((1 << RPM_W) - 1))
                           ? '1 : dv_quo[RPM_W-1:0];
            speed_rpm   <= rspr_quant(quo_sat, sdiv);
            stopped     <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_value <= '0;
        end else if (state_reg == st_pwr && dv_done) begin
            power_value <= pwr_neg_reg ? 32'(-pwr_mag) : pwr_mag;
        end
    end

    assign filter_sel = cfg_reg[`RSPR_F_FILT +: 2];

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              aw_got_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              w_got_reg;
    logic [23:0]       cfg_merge;

    always_comb begin
        cfg_merge = {7'h00, cfg_reg};
        for (int b = 0; b < 3; b++) begin
            if (w_strb_reg[b]) begin
                cfg_merge[b*8 +: 8] = w_data_reg[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RSPR_RESP_OKAY;
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            cfg_reg       <= `RSPR_CFG_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_got_reg    <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                w_got_reg    <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!w_got_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RSPR_RESP_OKAY;
                // Fields are independent bits, so no write drags another
                if (aw_addr_reg == ADDR_W'(`RSPR_OFS_CFG)) begin
                    cfg_reg <= cfg_merge[`RSPR_CFG_BITS-1:0];
                end else if (aw_addr_reg != ADDR_W'(`RSPR_OFS_SPEED)
                          && aw_addr_reg != ADDR_W'(`RSPR_OFS_POWER)
                          && aw_addr_reg != ADDR_W'(`RSPR_OFS_STATUS)
                          && aw_addr_reg != ADDR_W'(`RSPR_OFS_PERIOD)) begin
                    s_axi_bresp <= `RSPR_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RSPR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RSPR_RESP_OKAY;
            if (s_axi_araddr == ADDR_W'(`RSPR_OFS_CFG)) begin
                s_axi_rdata <= {15'h0000, cfg_reg};
            end else if (s_axi_araddr == ADDR_W'(`RSPR_OFS_SPEED)) begin
                s_axi_rdata <= speed_rpm;
            end else if (s_axi_araddr == ADDR_W'(`RSPR_OFS_POWER)) begin
                s_axi_rdata <= power_value;
            end else if (s_axi_araddr == ADDR_W'(`RSPR_OFS_STATUS)) begin
                s_axi_rdata <= {29'h00000000, dv_busy, armed_reg, stopped};
            end else if (s_axi_araddr == ADDR_W'(`RSPR_OFS_PERIOD)) begin
                s_axi_rdata <= period_reg;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= `RSPR_RESP_SLVERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : rspr_top
